// File: pft_pkg.sv
// Purpose: Constants, register map and types for the program flash table access unit.
// Assumes: One 125 MHz clock, classic Wishbone slave, 8-bit registers in byte lane 0.
// Notes: Registers are single bytes; the rules of the unit follow.
// Function
// - Program and erase flash only in 64-byte rows.
// - Table read returns one byte each time.
// - No bulk erase path; row erase only.
// - Stall instruction fetch until timer ends cycle.
// - All transfers pass the 8-bit table latch.
// - Table store fills holding byte pointer[5:0].
// - Program cycle writes row pointer[21:6].
// - Row erase uses pointer[21:6], ignores [5:0].
// - Table read uses all 22 pointer bits.
// - Pointer is 22 bits from three bytes.
// - Four pointer modes: none, post-inc/dec, pre-inc.
// - Auto step touches only the low 21 bits.
// - Unlock port stores nothing, reads zero.
// - Space select bit 7 picks flash or EEPROM.
// - Config select bit 6 overrides space select.
// - Erase select bit 4 erases; completion clears.
// - Enable latch bit 2 clear inhibits cycles.
// - Abort flag bit 3 on warm reset mid-cycle or misuse.
// - Go bit 1 set-only, hardware clears.
// - Done flag set at cycle end, software clears.
// - EEPROM read bit 0 one-cycle, refused sometimes.
// - Go needs unlock pair 55h then 0AAh.
// - Holding bytes reset to FFh; FFh keeps byte.
`default_nettype none
package pft_pkg;
  // Word offsets on the Wishbone bus
  localparam logic [7:0] PFT_OFS_CONTROL = 8'h00;
  localparam logic [7:0] PFT_OFS_UNLOCK = 8'h04;
  localparam logic [7:0] PFT_OFS_LATCH = 8'h08;
  localparam logic [7:0] PFT_OFS_PTR_LOW = 8'h0c;
  localparam logic [7:0] PFT_OFS_PTR_HIGH = 8'h10;
  localparam logic [7:0] PFT_OFS_PTR_UPPER = 8'h14;
  localparam logic [7:0] PFT_OFS_TABLE_OP = 8'h18;
  localparam logic [7:0] PFT_OFS_FLAGS2 = 8'h1c;
  localparam logic [7:0] PFT_OFS_STATUS = 8'h20;
  // Bit positions in the control, flags and table operation registers
  localparam int PFT_BIT_SPACE = 7;
  localparam int PFT_BIT_CFG = 6;
  localparam int PFT_BIT_ERASE = 4;
  localparam int PFT_BIT_ABORT = 3;
  localparam int PFT_BIT_ENABLE = 2;
  localparam int PFT_BIT_GO = 1;
  localparam int PFT_BIT_EERD = 0;
  localparam int PFT_BIT_DONE = 4;
  localparam int PFT_BIT_STORE = 2;
  // Unlock keys and erased byte value
  localparam logic [7:0] PFT_KEY_FIRST = 8'h55;
  localparam logic [7:0] PFT_KEY_SECOND = 8'haa;
  localparam logic [7:0] PFT_HOLD_ERASED = 8'hff;
  localparam logic [1:0] PFT_UNL_IDLE = 2'h0;
  localparam logic [1:0] PFT_UNL_HALF = 2'h1;
  localparam logic [1:0] PFT_UNL_ARMED = 2'h2;
  // Geometry
  localparam int PFT_ROW_BYTES = 64;
  localparam int PFT_IDX_W = 6;
  localparam int PFT_PTR_W = 22;
  localparam int PFT_STEP_W = 21;
  localparam int PFT_ROW_W = 16;
  localparam int PFT_UPPER_W = 6;
  // Pointer modes of a table operation
  localparam logic [1:0] PFT_MODE_KEEP = 2'h0;
  localparam logic [1:0] PFT_MODE_POSTINC = 2'h1;
  localparam logic [1:0] PFT_MODE_POSTDEC = 2'h2;
  localparam logic [1:0] PFT_MODE_PREINC = 2'h3;
  // Targets of a timed cycle
  localparam logic [1:0] PFT_TGT_EEPROM = 2'h0;
  localparam logic [1:0] PFT_TGT_FLASH = 2'h1;
  localparam logic [1:0] PFT_TGT_CONFIG = 2'h2;
  // Timing
  localparam int PFT_CLK_MHZ = 125;
  localparam int PFT_PROG_TIME_US = 2000;
  localparam int PFT_PROG_CYCLES = PFT_PROG_TIME_US * PFT_CLK_MHZ;
  localparam int PFT_CNT_W = 20;

  typedef enum logic [1:0] {
    PFT_ST_IDLE = 2'b00,
    PFT_ST_READ = 2'b01,
    PFT_ST_PROG = 2'b10
  } pft_fsm_t;

  typedef struct packed {
    pft_fsm_t fsm;
    logic [PFT_ROW_BYTES-1:0][7:0] hold;
    logic [PFT_PTR_W-1:0] ptr;
    logic [7:0] latch;
    logic space;
    logic cfg;
    logic erase;
    logic abort;
    logic enable;
    logic go;
    logic eerd;
    logic done;
    logic [1:0] unlock;
    logic [1:0] pend_mode;
    logic [PFT_CNT_W-1:0] cnt;
    logic op_erase;
    logic [1:0] op_target;
    logic [PFT_ROW_W-1:0] op_row;
    logic ee_rd;
    logic commit;
    logic mem_rd;
    logic [PFT_PTR_W-1:0] mem_addr;
    logic ack;
    logic [31:0] rdat;
  } pft_state_t;
endpackage
`default_nettype wire

// File: pft_table_access.sv
// Purpose: Table read/store, holding rows and self-timed row erase/write sequencer.
// Assumes: Flash array and EEPROM sit outside on the same clock; warm_rst_i is any
//   non power-on reset of the core.
// Notes: Registers are 8 bits wide in byte lane 0; upper bits read zero.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pft_table_access
  import pft_pkg::*;
#(
  parameter int PROG_CYCLES = PFT_PROG_CYCLES
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic warm_rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Program memory read port
  output logic mem_rd_o,
  output logic [PFT_PTR_W-1:0] mem_addr_o,
  input wire logic mem_rd_ack_i,
  input wire logic [7:0] mem_rd_data_i,
  // Timed cycle commit to the array
  output logic nvm_commit_o,
  output logic nvm_erase_o,
  output logic [1:0] nvm_target_o,
  output logic [PFT_ROW_W-1:0] nvm_row_o,
  output logic [PFT_ROW_BYTES*8-1:0] nvm_data_o,
  // EEPROM read, stall and done flag
  output logic ee_rd_o,
  output logic fetch_stall_o,
  output logic nvm_done_flag_o
);

  localparam logic [PFT_CNT_W-1:0] CNT_LAST = PFT_CNT_W'(PROG_CYCLES - 1);

  pft_state_t st_reg;
  pft_state_t st_next;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] wdat;

  // Step only the low 21 bits so the config space bit stays put
  function automatic logic [PFT_PTR_W-1:0] ptr_step(input logic [PFT_PTR_W-1:0] p,
                                                    input logic up);
    logic [PFT_STEP_W-1:0] low;
    low = up ? p[PFT_STEP_W-1:0] + 1'b1 : p[PFT_STEP_W-1:0] - 1'b1;
    return {p[PFT_PTR_W-1], low};
  endfunction

  // Pointer value after the operation for each mode
  function automatic logic [PFT_PTR_W-1:0] ptr_post(input logic [PFT_PTR_W-1:0] p,
                                                    input logic [1:0] mode);
    logic [PFT_PTR_W-1:0] q;
    q = p;
    if (mode == PFT_MODE_POSTINC) begin
      q = ptr_step(p, 1'b1);
    end else if (mode == PFT_MODE_POSTDEC) begin
      q = ptr_step(p, 1'b0);
    end
    return q;
  endfunction

  // Target of a timed cycle from the two select bits
  function automatic logic [1:0] sel_target(input logic cfg, input logic space);
    logic [1:0] t;
    t = space ? PFT_TGT_FLASH : PFT_TGT_EEPROM;
    if (cfg) begin
      t = PFT_TGT_CONFIG;
    end
    return t;
  endfunction

  // Bus strobes; only byte lane 0 carries register data
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & ~st_reg.ack & wb_sel_i[0];
  assign bus_rd = bus_req & ~wb_we_i & ~st_reg.ack;
  assign wdat = wb_dat_i[7:0];

  // Next state of the whole unit
  always_comb begin
    logic [PFT_PTR_W-1:0] op_addr;
    logic [1:0] op_mode;
    op_addr = st_reg.ptr;
    op_mode = wdat[1:0];
    st_next = st_reg;
    st_next.commit = 1'b0;
    st_next.ee_rd = 1'b0;
    st_next.eerd = 1'b0;
    st_next.ack = bus_req & ~st_reg.ack;
    st_next.rdat = 32'h0;
    // Holding row returns to erased once the write has been handed over
    if (st_reg.commit && !st_reg.op_erase) begin
      st_next.hold = {PFT_ROW_BYTES{PFT_HOLD_ERASED}};
    end
    // Register reads
    if (bus_rd) begin
      case (wb_adr_i)
        PFT_OFS_CONTROL: begin
          st_next.rdat[7:0] = {st_reg.space, st_reg.cfg, 1'b0, st_reg.erase,
                               st_reg.abort, st_reg.enable, st_reg.go, st_reg.eerd};
        end
        PFT_OFS_LATCH: st_next.rdat[7:0] = st_reg.latch;
        PFT_OFS_PTR_LOW: st_next.rdat[7:0] = st_reg.ptr[7:0];
        PFT_OFS_PTR_HIGH: st_next.rdat[7:0] = st_reg.ptr[15:8];
        PFT_OFS_PTR_UPPER: st_next.rdat[PFT_UPPER_W-1:0] = st_reg.ptr[PFT_PTR_W-1:16];
        PFT_OFS_FLAGS2: st_next.rdat[PFT_BIT_DONE] = st_reg.done;
        PFT_OFS_STATUS: st_next.rdat[3:0] = {st_reg.unlock, st_reg.fsm};
        default: st_next.rdat = 32'h0; // Unlock port reads zero
      endcase
    end
    // Register writes
    if (bus_wr) begin
      case (wb_adr_i)
        PFT_OFS_CONTROL: begin
          st_next.space = wdat[PFT_BIT_SPACE];
          st_next.cfg = wdat[PFT_BIT_CFG];
          st_next.erase = wdat[PFT_BIT_ERASE];
          st_next.abort = wdat[PFT_BIT_ABORT];
          st_next.enable = wdat[PFT_BIT_ENABLE];
          // Read go refused while either select bit is one
          if (wdat[PFT_BIT_EERD] && !wdat[PFT_BIT_SPACE] && !wdat[PFT_BIT_CFG]) begin
            st_next.eerd = 1'b1;
            st_next.ee_rd = 1'b1;
          end
          // Go is set-only; a clear written here has no effect
          if (wdat[PFT_BIT_GO] && !st_reg.go) begin
            if (st_next.enable && st_reg.unlock == PFT_UNL_ARMED &&
                st_reg.fsm == PFT_ST_IDLE) begin
              st_next.go = 1'b1;
              st_next.fsm = PFT_ST_PROG;
              st_next.cnt = '0;
              st_next.op_erase = wdat[PFT_BIT_ERASE];
              st_next.op_target = sel_target(wdat[PFT_BIT_CFG], wdat[PFT_BIT_SPACE]);
              st_next.op_row = st_reg.ptr[PFT_PTR_W-1:PFT_IDX_W];
            end else begin
              st_next.abort = 1'b1;
            end
            st_next.unlock = PFT_UNL_IDLE;
          end
        end
        PFT_OFS_UNLOCK: begin
          // Only a sequencing tracker; no data is kept
          if (wdat == PFT_KEY_FIRST) begin
            st_next.unlock = PFT_UNL_HALF;
          end else if (wdat == PFT_KEY_SECOND && st_reg.unlock == PFT_UNL_HALF) begin
            st_next.unlock = PFT_UNL_ARMED;
          end else begin
            st_next.unlock = PFT_UNL_IDLE;
          end
        end
        PFT_OFS_LATCH: begin
          if (st_reg.fsm != PFT_ST_READ) begin
            st_next.latch = wdat;
          end
        end
        PFT_OFS_PTR_LOW: st_next.ptr[7:0] = wdat;
        PFT_OFS_PTR_HIGH: st_next.ptr[15:8] = wdat;
        PFT_OFS_PTR_UPPER: st_next.ptr[PFT_PTR_W-1:16] = wdat[PFT_UPPER_W-1:0];
        PFT_OFS_TABLE_OP: begin
          // Ignored while a read or timed cycle is running
          if (st_reg.fsm == PFT_ST_IDLE) begin
            if (op_mode == PFT_MODE_PREINC) begin
              op_addr = ptr_step(st_reg.ptr, 1'b1);
            end
            if (wdat[PFT_BIT_STORE]) begin
              // Store touches the holding row only, never the array
              st_next.hold[op_addr[PFT_IDX_W-1:0]] = st_reg.latch;
              st_next.ptr = ptr_post(op_addr, op_mode);
            end else begin
              st_next.mem_rd = 1'b1;
              st_next.mem_addr = op_addr;
              st_next.ptr = op_addr;
              st_next.pend_mode = op_mode;
              st_next.fsm = PFT_ST_READ;
            end
          end
        end
        PFT_OFS_FLAGS2: st_next.done = wdat[PFT_BIT_DONE];
        default: st_next.done = st_next.done;
      endcase
    end
    // Sequencer
    case (st_reg.fsm)
      PFT_ST_READ: begin
        if (mem_rd_ack_i) begin
          st_next.latch = mem_rd_data_i;
          st_next.mem_rd = 1'b0;
          st_next.ptr = ptr_post(st_reg.ptr, st_reg.pend_mode);
          st_next.fsm = PFT_ST_IDLE;
        end
      end
      PFT_ST_PROG: begin
        // Internal timer ends the cycle; the array sees one whole row
        if (st_reg.cnt == CNT_LAST) begin
          st_next.commit = 1'b1;
          st_next.go = 1'b0;
          st_next.done = 1'b1;
          st_next.fsm = PFT_ST_IDLE;
          if (st_reg.op_erase) begin
            st_next.erase = 1'b0;
          end
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      PFT_ST_IDLE: st_next.cnt = '0;
      default: st_next.fsm = PFT_ST_IDLE;
    endcase
    // A warm reset cuts a running cycle short; selects stay for tracing
    if (warm_rst_i) begin
      if (st_reg.fsm == PFT_ST_PROG) begin
        st_next.abort = 1'b1;
        st_next.commit = 1'b0;
      end
      st_next.go = 1'b0;
      st_next.mem_rd = 1'b0;
      st_next.unlock = PFT_UNL_IDLE;
      st_next.fsm = PFT_ST_IDLE;
    end
  end

  // State register; power-on leaves the holding row erased
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.hold <= {PFT_ROW_BYTES{PFT_HOLD_ERASED}};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign mem_rd_o = st_reg.mem_rd;
  assign mem_addr_o = st_reg.mem_addr;
  assign nvm_commit_o = st_reg.commit;
  assign nvm_erase_o = st_reg.op_erase;
  assign nvm_target_o = st_reg.op_target;
  assign nvm_row_o = st_reg.op_row;
  assign nvm_data_o = st_reg.hold;
  assign ee_rd_o = st_reg.ee_rd;
  assign fetch_stall_o = st_reg.go; // Go stands exactly while the timed cycle runs
  assign nvm_done_flag_o = st_reg.done;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_unlock_reads_zero;
    bus_rd && wb_adr_i == PFT_OFS_UNLOCK |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero)
    else $error("unlock port read not zero");

  property p_start_needs_key_and_enable;
    $rose(fetch_stall_o) |-> $past(st_reg.unlock) == PFT_UNL_ARMED && st_reg.enable;
  endproperty
  a_start_needs_key_and_enable: assert property (p_start_needs_key_and_enable)
    else $error("cycle started without unlock or enable");

  property p_bad_go_aborts;
    bus_wr && wb_adr_i == PFT_OFS_CONTROL && wdat[PFT_BIT_GO] && !st_reg.go &&
      !wdat[PFT_BIT_ENABLE] && !warm_rst_i |=> st_reg.abort && !fetch_stall_o;
  endproperty
  a_bad_go_aborts: assert property (p_bad_go_aborts)
    else $error("go without enable did not abort");

  property p_commit_clears_go;
    nvm_commit_o |-> !st_reg.go && nvm_done_flag_o && $past(fetch_stall_o);
  endproperty
  a_commit_clears_go: assert property (p_commit_clears_go)
    else $error("go or done wrong at commit");

  property p_hold_erased_after_write;
    nvm_commit_o && !nvm_erase_o |=> nvm_data_o == {PFT_ROW_BYTES{PFT_HOLD_ERASED}};
  endproperty
  a_hold_erased_after_write: assert property (p_hold_erased_after_write)
    else $error("holding row not erased after write");

  property p_eeprom_read_refused;
    bus_wr && wb_adr_i == PFT_OFS_CONTROL && wdat[PFT_BIT_EERD] &&
      (wdat[PFT_BIT_SPACE] || wdat[PFT_BIT_CFG]) |=> !ee_rd_o;
  endproperty
  a_eeprom_read_refused: assert property (p_eeprom_read_refused)
    else $error("eeprom read not refused");

  property p_top_bit_kept;
    !(bus_wr && wb_adr_i == PFT_OFS_PTR_UPPER) |=>
      st_reg.ptr[PFT_PTR_W-1] == $past(st_reg.ptr[PFT_PTR_W-1]);
  endproperty
  a_top_bit_kept: assert property (p_top_bit_kept)
    else $error("pointer top bit changed by stepping");

  property p_warm_reset_aborts;
    fetch_stall_o && warm_rst_i |=> st_reg.abort && !fetch_stall_o && !nvm_commit_o;
  endproperty
  a_warm_reset_aborts: assert property (p_warm_reset_aborts)
    else $error("reset during cycle not flagged");

  property p_erase_clears_select;
    nvm_commit_o && nvm_erase_o |-> !st_reg.erase;
  endproperty
  a_erase_clears_select: assert property (p_erase_clears_select)
    else $error("erase select not cleared at completion");

  // Sequencer and datapath checks; stall must match the state flop
  property p_stall_tracks_cycle;
    fetch_stall_o == (st_reg.fsm == PFT_ST_PROG);
  endproperty
  a_stall_tracks_cycle: assert property (p_stall_tracks_cycle)
    else $error("stall does not match timed state");

  property p_stall_held;
    fetch_stall_o && !warm_rst_i && st_reg.cnt != CNT_LAST |=> fetch_stall_o;
  endproperty
  a_stall_held: assert property (p_stall_held)
    else $error("timed cycle ended before its count");

  property p_store_no_array;
    bus_wr && wb_adr_i == PFT_OFS_TABLE_OP && wdat[PFT_BIT_STORE] && !mem_rd_o |=>
      !mem_rd_o;
  endproperty
  a_store_no_array: assert property (p_store_no_array)
    else $error("table store touched the array");

  property p_read_request;
    bus_wr && wb_adr_i == PFT_OFS_TABLE_OP && !wdat[PFT_BIT_STORE] &&
      st_reg.fsm == PFT_ST_IDLE && !warm_rst_i |=> mem_rd_o && mem_addr_o == st_reg.ptr;
  endproperty
  a_read_request: assert property (p_read_request)
    else $error("table read address wrong");

  property p_read_lands;
    st_reg.fsm == PFT_ST_READ && mem_rd_ack_i && !warm_rst_i |=>
      !mem_rd_o && st_reg.latch == $past(mem_rd_data_i);
  endproperty
  a_read_lands: assert property (p_read_lands)
    else $error("read byte not in latch");

  property p_go_set_only;
    $fell(st_reg.go) |-> nvm_commit_o || $past(warm_rst_i);
  endproperty
  a_go_set_only: assert property (p_go_set_only)
    else $error("go cleared without completion");

  property p_row_captured;
    $rose(fetch_stall_o) |-> nvm_row_o == $past(st_reg.ptr[PFT_PTR_W-1:PFT_IDX_W]);
  endproperty
  a_row_captured: assert property (p_row_captured)
    else $error("row not taken from pointer");

  property p_eeprom_read_pulse;
    ee_rd_o |=> !ee_rd_o;
  endproperty
  a_eeprom_read_pulse: assert property (p_eeprom_read_pulse)
    else $error("eeprom read longer than one cycle");

  property p_target_from_selects;
    $rose(fetch_stall_o) |->
      nvm_target_o == (st_reg.cfg ? PFT_TGT_CONFIG :
                       st_reg.space ? PFT_TGT_FLASH : PFT_TGT_EEPROM);
  endproperty
  a_target_from_selects: assert property (p_target_from_selects)
    else $error("cycle target wrong");

endmodule // pft_table_access
`default_nettype wire

// File: pft_array_model.sv
// Purpose: Program memory array model answering table reads.
// Assumes: Same clock as the unit; one read outstanding at a time.
// Notes: Data line toggles outside the answer cycle so stale bytes never pass.
`timescale 1ns/1ps
`default_nettype none
module pft_array_model
  import pft_pkg::*;
(
  // Clock and pacing
  input wire logic clk_i,
  input wire logic slow_i,
  // Read port
  input wire logic mem_rd_i,
  input wire logic [PFT_PTR_W-1:0] mem_addr_i,
  output logic mem_rd_ack_o,
  output logic [7:0] mem_rd_data_o
);
  logic [3:0] wait_reg;

  initial begin
    wait_reg = 4'h0;
    mem_rd_ack_o = 1'b0;
    mem_rd_data_o = 8'h00;
  end

  // Slow mode waits five cycles to stress the held request
  always @(posedge clk_i) begin
    if (mem_rd_i && !mem_rd_ack_o && wait_reg == (slow_i ? 4'h5 : 4'h0)) begin
      mem_rd_ack_o <= 1'b1;
      mem_rd_data_o <= mem_addr_i[7:0] ^ {mem_addr_i[21:16], 2'b01};
      wait_reg <= 4'h0;
    end else begin
      mem_rd_ack_o <= 1'b0;
      mem_rd_data_o <= ~mem_rd_data_o;
      wait_reg <= (mem_rd_i && !mem_rd_ack_o) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule // pft_array_model
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the table access unit.
// Assumes: Short timed cycle of 16 clocks; LFSR stimulus from a fixed seed.
// Notes: Expectations come from bench functions only.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top
  import pft_pkg::*;
;
  localparam int PC = 16;
  logic clk_i = 1'b0, rst_i = 1'b1, warm_rst_i = 1'b0, slow = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, mem_rd_o, mem_rd_ack_i, nvm_commit_o, nvm_erase_o, c_erase;
  logic ee_rd_o, fetch_stall_o, nvm_done_flag_o;
  logic [7:0] mem_rd_data_i, q, b;
  logic [1:0] nvm_target_o, c_tgt, tgt;
  logic [21:0] mem_addr_o, rd_addr, p, q22;
  logic [15:0] nvm_row_o, c_row;
  logic [511:0] nvm_data_o, c_data, x_row;
  logic [5:0] ix;
  logic [31:0] lfsr_reg = 32'hae67;
  int fail_count = 0, checked = 0, commits = 0, ee_cnt = 0, stall_cnt = 0;
  int c0, s0, i, n;

  pft_table_access #(.PROG_CYCLES(PC)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .warm_rst_i(warm_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
    .mem_rd_ack_i(mem_rd_ack_i), .mem_rd_data_i(mem_rd_data_i),
    .nvm_commit_o(nvm_commit_o), .nvm_erase_o(nvm_erase_o), .nvm_target_o(nvm_target_o),
    .nvm_row_o(nvm_row_o), .nvm_data_o(nvm_data_o), .ee_rd_o(ee_rd_o),
    .fetch_stall_o(fetch_stall_o), .nvm_done_flag_o(nvm_done_flag_o));
  pft_array_model arr_u (.clk_i(clk_i), .slow_i(slow), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .mem_rd_ack_o(mem_rd_ack_i), .mem_rd_data_o(mem_rd_data_i));

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // Watch commits, stall length, read requests and EEPROM pulses
  always @(posedge clk_i) begin
    if (mem_rd_o === 1'b1) rd_addr <= mem_addr_o;
    if (ee_rd_o === 1'b1) ee_cnt <= ee_cnt + 1;
    if (fetch_stall_o === 1'b1) stall_cnt <= stall_cnt + 1;
    if (nvm_commit_o === 1'b1) begin
      commits <= commits + 1;
      c_row <= nvm_row_o;
      c_erase <= nvm_erase_o;
      c_tgt <= nvm_target_o;
      c_data <= nvm_data_o;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Auto step touches the low 21 bits only
  function automatic logic [21:0] step(input logic [21:0] v, input logic [1:0] m);
    logic [20:0] lo;
    lo = v[20:0];
    if (m == PFT_MODE_POSTDEC) lo = lo - 21'h1;
    else if (m != PFT_MODE_KEEP) lo = lo + 21'h1;
    return {v[21], lo};
  endfunction

  // One classic cycle; read byte lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic setp(input logic [21:0] v);
    wb(1'b1, PFT_OFS_PTR_LOW, v[7:0]);
    wb(1'b1, PFT_OFS_PTR_HIGH, v[15:8]);
    wb(1'b1, PFT_OFS_PTR_UPPER, {2'b00, v[21:16]});
  endtask

  task automatic unlock;
    wb(1'b1, PFT_OFS_UNLOCK, PFT_KEY_FIRST);
    wb(1'b1, PFT_OFS_UNLOCK, PFT_KEY_SECOND);
  endtask

  task automatic summarize;
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state, key port and an unmapped place
    wb(1'b0, PFT_OFS_CONTROL, 8'h00);
    `CHK(q, 8'h00)
    wb(1'b1, PFT_OFS_UNLOCK, PFT_KEY_FIRST);
    wb(1'b0, PFT_OFS_UNLOCK, 8'h00);
    `CHK(q, 8'h00)
    wb(1'b0, 8'h3c, 8'h00);
    `CHK(q, 8'h00)
    // Table reads in every pointer mode, wrap corners in the second and third passes
    for (i = 0; i < 8; i++) begin
      lfsr_reg = lfsr(lfsr_reg);
      p = (i == 1) ? 22'h3fffff : (i == 2) ? 22'h200000 : lfsr_reg[21:0];
      slow <= i[2];
      setp(p);
      wb(1'b1, PFT_OFS_TABLE_OP, {6'h00, i[1:0]});
      n = 0;
      q = 8'h01;
      while (q[1:0] != 2'h0 && n < 40) begin
        wb(1'b0, PFT_OFS_STATUS, 8'h00);
        n++;
      end
      `CHK(q[1:0], 2'h0)
      p = (i[1:0] == PFT_MODE_PREINC) ? step(p, i[1:0]) : p;
      `CHK(rd_addr, p)
      wb(1'b0, PFT_OFS_LATCH, 8'h00);
      `CHK(q, p[7:0] ^ {p[21:16], 2'b01})
      wb(1'b0, PFT_OFS_PTR_LOW, 8'h00);
      q22[7:0] = q;
      wb(1'b0, PFT_OFS_PTR_HIGH, 8'h00);
      q22[15:8] = q;
      wb(1'b0, PFT_OFS_PTR_UPPER, 8'h00);
      q22[21:16] = q[5:0];
      p = (i[1:0] == PFT_MODE_PREINC) ? p : step(p, i[1:0]);
      `CHK(q22, p)
    end
    // Timed flash write, EEPROM erase, and config write and erase
    for (i = 0; i < 4; i++) begin
      lfsr_reg = lfsr(lfsr_reg);
      p = {lfsr_reg[21:2], 2'b00};
      x_row = '1;
      setp(p);
      for (int s = 0; s < 2 && !i[0]; s++) begin
        b = lfsr_reg[8*s+:8] ^ 8'h3c;
        ix = p[5:0] + 6'(s);
        x_row[8*ix+:8] = b;
        wb(1'b1, PFT_OFS_LATCH, b);
        wb(1'b1, PFT_OFS_TABLE_OP, 8'h05);
      end
      unlock();
      b = {~i[0], i[1], 1'b0, i[0], 4'b0110};
      tgt = i[1] ? PFT_TGT_CONFIG : (i[0] ? PFT_TGT_EEPROM : PFT_TGT_FLASH);
      c0 = commits;
      s0 = stall_cnt;
      wb(1'b1, PFT_OFS_CONTROL, b);
      wb(1'b1, PFT_OFS_CONTROL, b & 8'hfd);
      wb(1'b0, PFT_OFS_CONTROL, 8'h00);
      `CHK(q[1], 1'b1)
      `CHK(fetch_stall_o, 1'b1)
      for (n = 0; n < 60 && commits == c0; n++) @(posedge clk_i);
      `CHK(commits - c0, 1)
      `CHK(stall_cnt - s0, PC)
      `CHK(c_row, p[21:6])
      `CHK(c_erase, i[0])
      `CHK(c_tgt, tgt)
      if (!i[0]) `CHK(c_data, x_row)
      wb(1'b0, PFT_OFS_CONTROL, 8'h00);
      `CHK(q[4:1], 4'b0010)
      `CHK(nvm_done_flag_o, 1'b1)
      wb(1'b1, PFT_OFS_FLAGS2, 8'h00);
      wb(1'b0, PFT_OFS_FLAGS2, 8'h00);
      `CHK(q[4], 1'b0)
    end
    // Go without the key pair, then without enable
    for (i = 0; i < 2; i++) begin
      wb(1'b1, PFT_OFS_CONTROL, 8'h00);
      if (i == 1) unlock();
      c0 = commits;
      wb(1'b1, PFT_OFS_CONTROL, i[0] ? 8'h82 : 8'h86);
      wb(1'b0, PFT_OFS_CONTROL, 8'h00);
      `CHK(q[3:1], {1'b1, ~i[0], 1'b0})
      `CHK(fetch_stall_o, 1'b0)
    end
    // Warm reset in mid-cycle keeps the selects
    unlock();
    c0 = commits;
    wb(1'b1, PFT_OFS_CONTROL, 8'hc6);
    repeat (4) @(posedge clk_i);
    warm_rst_i <= 1'b1;
    @(posedge clk_i);
    warm_rst_i <= 1'b0;
    repeat (PC) @(posedge clk_i);
    wb(1'b0, PFT_OFS_CONTROL, 8'h00);
    `CHK(q, 8'hcc)
    `CHK(commits - c0, 0)
    // EEPROM read refused while flash is selected
    for (i = 0; i < 2; i++) begin
      c0 = ee_cnt;
      wb(1'b1, PFT_OFS_CONTROL, i[0] ? 8'h81 : 8'h01);
      repeat (3) @(posedge clk_i);
      `CHK(ee_cnt - c0, 1 - i)
    end
    summarize();
  end
endmodule // tb_top
`default_nettype wire
